// ==== common/mixer_defs.svh ====
`ifndef MIXER_DEFS_SVH
`define MIXER_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define MIX_CLK_KHZ        20000
`define MIX_OFFSET_HZ      500
`define MIX_BEAT_MAX_HZ    1000
`define MIX_TIMEOUT_MS     1000
`define MIX_TIMEOUT_CYC    (`MIX_TIMEOUT_MS * `MIX_CLK_KHZ)

// ----------------------------------------------------------------------
// Field widths and reset values
// ----------------------------------------------------------------------
`define MIX_REF_CNT_W      32
`define MIX_PRE_CNT_W      8
`define MIX_CNT_W          25
`define MIX_DIV_LOG2_W     5
`define MIX_PRE_LOG2_W     3
`define MIX_DIV_LOG2_DEF   8
`define MIX_BEAT_RST       1'b0

`endif

// ==== common/mixer_pkg.sv ====
`include "mixer_defs.svh"

package mixer_pkg;

    // Period meter arming state
    typedef enum logic {
        MEAS_IDLE   = 1'b0,
        MEAS_TIMING = 1'b1
    } meas_state_t;

    // Whole state of the mixer outside the period meter
    typedef struct packed {
        logic                          sens_d;
        logic [`MIX_PRE_CNT_W-1:0]     pre_cnt;
        logic [`MIX_REF_CNT_W-1:0]     ref_cnt;
        logic                          beat;
    } mix_state_t;

    // Whole state of the period meter
    typedef struct packed {
        meas_state_t                   mode;
        logic                          beat_d;
        logic [`MIX_CNT_W-1:0]         count;
        logic [`MIX_CNT_W-1:0]         period;
        logic                          valid;
        logic                          stale;
    } meas_state_s_t;

    // All-ones mask of the low n bits
    function automatic logic [`MIX_REF_CNT_W-1:0] low_mask(input logic [`MIX_DIV_LOG2_W-1:0] n);
        low_mask = ({{(`MIX_REF_CNT_W-1){1'b0}}, 1'b1} << n) - {{(`MIX_REF_CNT_W-1){1'b0}}, 1'b1};
    endfunction : low_mask

endpackage : mixer_pkg

// ==== common/beat_if.sv ====
`timescale 1ns/100ps
`include "mixer_defs.svh"

interface beat_if;
    logic                   beat;
    logic [`MIX_CNT_W-1:0]  period;
    logic                   valid;
    logic                   stale;

    modport mixer (output beat, input period, input valid, input stale);
    modport meter (input beat, output period, output valid, output stale);
endinterface : beat_if

// ==== src/beat_period_meter.sv ====
`timescale 1ns/100ps
`include "mixer_defs.svh"

module beat_period_meter
    import mixer_pkg::*;
#(
    parameter logic [`MIX_CNT_W-1:0] TIMEOUT_CYC = `MIX_CNT_W'(`MIX_TIMEOUT_CYC)
) (
    input  wire logic  i_clk,
    input  wire logic  i_resetn,
    beat_if.meter      bus
);

    meas_state_s_t st;
    meas_state_s_t next_st;
    logic          rise;

    // ------------------------------------------------------------------
    // Period counting
    // ------------------------------------------------------------------
    // Beat already lives on the reference clock, so no extra crossing
    assign rise = bus.beat & ~st.beat_d;

    // Count reference cycles from one beat rise to the next
    always_comb begin
        next_st        = st;
        next_st.beat_d = bus.beat;
        next_st.valid  = 1'b0;
        unique case (st.mode)
            MEAS_IDLE: begin
                if (rise) begin
                    next_st.mode  = MEAS_TIMING;
                    next_st.count = '0;
                end
            end
            MEAS_TIMING: begin
                if (rise) begin
                    next_st.period = st.count + `MIX_CNT_W'(1);
                    next_st.valid  = 1'b1;
                    next_st.stale  = 1'b0;
                    next_st.count  = '0;
                end else if (st.count == TIMEOUT_CYC - `MIX_CNT_W'(1)) begin
                    // Beat near zero: flag it and re-arm on the next rise
                    next_st.stale = 1'b1;
                    next_st.mode  = MEAS_IDLE;
                end else begin
                    next_st.count = st.count + `MIX_CNT_W'(1);
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '{mode: MEAS_IDLE, beat_d: 1'b0, count: '0, period: '0, valid: 1'b0, stale: 1'b0};
        end else begin
            st <= next_st;
        end
    end

    assign bus.period = st.period;
    assign bus.valid  = st.valid;
    assign bus.stale  = st.stale;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_period_value: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (st.mode == MEAS_TIMING && rise) |=> (st.valid && st.period == $past(st.count) + `MIX_CNT_W'(1)))
        else $error("period not latched from count on beat rise");

    chk_count_restart: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rise |=> (st.count == '0 && st.mode == MEAS_TIMING))
        else $error("count not restarted on beat rise");

    chk_valid_cause: assert property (@(posedge i_clk) disable iff (!i_resetn)
        st.valid |-> ($past(rise) && $past(st.mode) == MEAS_TIMING))
        else $error("valid pulse without a timed beat rise");

endmodule : beat_period_meter

// ==== src/digital_heterodyne_mixer.sv ====
`timescale 1ns/100ps
`include "mixer_defs.svh"

module digital_heterodyne_mixer
    import mixer_pkg::*;
#(
    parameter logic [`MIX_CNT_W-1:0] TIMEOUT_CYC = `MIX_CNT_W'(`MIX_TIMEOUT_CYC)
) (
    input  wire logic                        I_REF_CLK,
    input  wire logic                        I_RESETN,
    input  wire logic                        I_SENSOR,
    input  wire logic [`MIX_DIV_LOG2_W-1:0]  I_REF_DIV_LOG2,
    input  wire logic [`MIX_PRE_LOG2_W-1:0]  I_PRE_LOG2,
    output logic                             O_REF_TICK,
    output logic                             O_BEAT,
    output logic [`MIX_CNT_W-1:0]            O_PERIOD,
    output logic                             O_PERIOD_VALID,
    output logic                             O_BEAT_STALE
);

    mix_state_t                  st;
    mix_state_t                  next_st;
    logic [`MIX_REF_CNT_W-1:0]   ref_mask;
    logic                        ref_tick;
    logic                        sens_rise;
    logic                        pre_sig;
    logic [`MIX_PRE_LOG2_W-1:0]  pre_bit;

    beat_if bus ();

    // ------------------------------------------------------------------
    // Reference divider
    // ------------------------------------------------------------------
    // Tick once per 2^n clocks; a free counter keeps the phase steady
    // when the ratio is changed, at the cost of one odd first period.
    assign ref_mask = low_mask(I_REF_DIV_LOG2);
    assign ref_tick = (st.ref_cnt & ref_mask) == ref_mask;

    // ------------------------------------------------------------------
    // Sensor prescaler
    // ------------------------------------------------------------------
    // Sensor pin is taken as synchronous to the reference clock
    assign sens_rise = I_SENSOR & ~st.sens_d;
    assign pre_bit   = I_PRE_LOG2 - `MIX_PRE_LOG2_W'(1);

    // Bit k of the edge counter divides by 2^(k+1); zero is bypass
    always_comb begin
        if (I_PRE_LOG2 == '0) begin
            pre_sig = I_SENSOR;
        end else begin
            pre_sig = st.pre_cnt[pre_bit];
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st         = st;
        next_st.sens_d  = I_SENSOR;
        next_st.ref_cnt = st.ref_cnt + `MIX_REF_CNT_W'(1);
        if (sens_rise) begin
            next_st.pre_cnt = st.pre_cnt + `MIX_PRE_CNT_W'(1);
        end
        // The one sampling flop: undersampling yields the beat
        if (ref_tick) begin
            next_st.beat = pre_sig;
        end
    end

    // State register
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st <= '{sens_d: 1'b0, pre_cnt: '0, ref_cnt: '0, beat: `MIX_BEAT_RST};
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Period meter
    // ------------------------------------------------------------------
    // Beat is a flop on this clock, so it is already synchronous
    assign bus.beat = st.beat;

    beat_period_meter #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_meter (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .bus      (bus)
    );

    // Outputs; tick is a handshake-style strobe and may be combinational
    assign O_REF_TICK     = ref_tick;
    assign O_BEAT         = st.beat;
    assign O_PERIOD       = bus.period;
    assign O_PERIOD_VALID = bus.valid;
    assign O_BEAT_STALE   = bus.stale;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_beat_sample: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        ref_tick |=> (st.beat == $past(pre_sig)))
        else $error("beat flop did not take the sensor sample");

    chk_beat_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        !ref_tick |=> $stable(st.beat))
        else $error("beat changed without a reference tick");

    chk_beat_change: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        $changed(st.beat) |-> ($past(ref_tick) && $past(pre_sig) != $past(st.beat)))
        else $error("beat edge not caused by a sampled sensor level");

    // Spacing is only promised while the ratio holds over the whole interval
    chk_tick_spacing: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (ref_tick && I_REF_DIV_LOG2 == `MIX_DIV_LOG2_W'(2)) ##1 (I_REF_DIV_LOG2 == `MIX_DIV_LOG2_W'(2)) [*4]
        |-> (ref_tick && !$past(ref_tick, 1) && !$past(ref_tick, 2) && !$past(ref_tick, 3)))
        else $error("reference tick spacing wrong for divide by four");

    chk_tick_every: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_REF_DIV_LOG2 == '0) |-> ref_tick)
        else $error("undivided reference must tick every cycle");

    chk_pre_bypass: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (I_PRE_LOG2 == '0) |-> (pre_sig == I_SENSOR))
        else $error("prescaler bypass does not pass the sensor");

    chk_pre_halve: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        (sens_rise && I_PRE_LOG2 == `MIX_PRE_LOG2_W'(1) && $stable(I_PRE_LOG2))
        ##1 (I_PRE_LOG2 == `MIX_PRE_LOG2_W'(1)) |-> (pre_sig != $past(pre_sig)))
        else $error("divide by two prescaler did not toggle on sensor rise");

    chk_period_out: assert property (@(posedge I_REF_CLK) disable iff (!I_RESETN)
        $rose(st.beat) |-> ##1 ($stable(O_PERIOD) || O_PERIOD_VALID))
        else $error("period output moved without valid");

endmodule : digital_heterodyne_mixer

// ==== verif/sensor_model.sv ====
`timescale 1ns/100ps

module sensor_model (
    input  wire logic       i_clk,
    input  wire logic       i_run,
    input  wire logic [7:0] i_hi,
    input  wire logic [7:0] i_lo,
    output logic            o_pulse
);
    logic [7:0] ph;

    // ------------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------------
    // Whole-cycle period keeps the train stable near the reference rate
    // A stopped sensor rests low, so the beat freezes and the meter goes stale
    initial begin
        ph = 8'h00;
        o_pulse = 1'b0;
        forever begin
            @(posedge i_clk);
            #1;
            if (!i_run) begin
                ph = 8'h00;
            end else begin
                ph = (ph + 8'h01 >= i_hi + i_lo) ? 8'h00 : ph + 8'h01;
            end
            o_pulse = i_run && (ph < i_hi);
        end
    end
endmodule : sensor_model

// ==== verif/digital_heterodyne_mixer_tb.sv ====
`timescale 1ns/100ps
`include "mixer_defs.svh"

module digital_heterodyne_mixer_tb;
    import mixer_pkg::*;

    localparam int TMO = 200;
    logic                       clk, rst_n, sens, run, tick, beat, valid, stale;
    logic [`MIX_DIV_LOG2_W-1:0] div;
    logic [`MIX_PRE_LOG2_W-1:0] pre, pre_q;
    logic [`MIX_CNT_W-1:0]      period;
    logic [7:0]                 hi, lo;
    logic                       tick_q, sens_q, beat_q, valid_q;
    int err_total, cmp_count, cyc, gap, skip, seed, i, j, k, tmp;
    int cs [6][4]; // div, sensor high, sensor low, prescale

    digital_heterodyne_mixer #(.TIMEOUT_CYC(`MIX_CNT_W'(TMO))) uut (
        .I_REF_CLK(clk), .I_RESETN(rst_n), .I_SENSOR(sens), .I_REF_DIV_LOG2(div), .I_PRE_LOG2(pre),
        .O_REF_TICK(tick), .O_BEAT(beat), .O_PERIOD(period), .O_PERIOD_VALID(valid), .O_BEAT_STALE(stale));
    sensor_model sensor (.i_clk(clk), .i_run(run), .i_hi(hi), .i_lo(lo), .o_pulse(sens));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk

    // Beat period in reference cycles: D*T/|T-D| with T the prescaled sensor period
    function automatic int exp_period(input int n, input int ts, input int p);
        int d;
        int t;
        d = 1 << n;
        t = ts << p;
        exp_period = d * t / ((t > d) ? t - d : d - t);
    endfunction : exp_period

    task automatic wait_valid();
        int n;
        n = 0;
        while (valid !== 1'b1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        if (n >= 1000) chk("valid_wait", 1, 0);
    endtask : wait_valid

    task automatic test_done();
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // ------------------------------------------------------------------
    // Clock, hang guard and cycle-level monitor
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Tests need a few thousand cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            test_done();
        end
    end

    // Sampled mid-cycle so registered outputs have settled
    always @(negedge clk) begin
        if (rst_n) begin
            if (tick_q === 1'b1 && pre_q == 0) chk("beat_sample", sens_q, beat);
            if (tick_q !== 1'b1) chk("beat_hold", beat_q, beat);
            if (valid_q === 1'b1) chk("valid_pulse", 0, valid);
            if (tick === 1'b1) begin
                if (skip == 0) chk("tick_gap", 1 << div, gap);
                else skip--;
                gap = 1;
            end else gap++;
        end
        tick_q = tick;
        sens_q = sens;
        beat_q = beat;
        valid_q = valid;
        pre_q = pre;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cs = '{'{3, 5, 5, 0}, '{3, 3, 2, 1}, '{2, 3, 3, 0}, '{4, 9, 9, 0}, '{3, 3, 3, 0}, '{4, 3, 2, 2}};
        {err_total, cmp_count, cyc, gap} = 0;
        seed = 35821;
        skip = 2;
        rst_n = 1'b0;
        run = 1'b0;
        div = 3;
        pre = 0;
        hi = 8'h05;
        lo = 8'h05;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk("reset_outs", 0, {tick, beat, period, valid, stale});
        @(posedge clk);
        #1 rst_n = 1'b1;
        // Shuffle the cases, then run each after a random pause
        for (i = 5; i > 0; i--) begin
            j = $unsigned($random(seed)) % (i + 1);
            for (k = 0; k < 4; k++) begin
                tmp = cs[i][k];
                cs[i][k] = cs[j][k];
                cs[j][k] = tmp;
            end
        end
        for (i = 0; i < 6; i++) begin
            run = 1'b0;
            repeat ($unsigned($random(seed)) % 8) @(posedge clk);
            #1;
            div = cs[i][0];
            hi = cs[i][1];
            lo = cs[i][2];
            pre = cs[i][3];
            run = 1'b1;
            skip = 2;
            // Early periods straddle the change and are discarded
            for (k = 0; k < 4; k++) begin
                @(negedge clk);
                wait_valid();
            end
            chk("beat_period", exp_period(cs[i][0], cs[i][1] + cs[i][2], cs[i][3]), period);
            chk("period_range", 1, period < TMO);
        end
        // Stopped sensor: meter must time out without a reading, then re-arm
        @(posedge clk);
        #1 run = 1'b0;
        k = 0;
        while (stale !== 1'b1 && k < 2 * TMO) begin
            @(negedge clk);
            if (valid === 1'b1) chk("valid_idle", 0, 1);
            k++;
        end
        chk("stale_set", 1, stale);
        @(posedge clk);
        #1;
        {div, hi, lo, pre, run} = {5'd3, 8'h05, 8'h05, 3'd0, 1'b1};
        @(negedge clk);
        wait_valid();
        chk("rearm_period", exp_period(3, 10, 0), period);
        chk("stale_clear", 0, stale);
        test_done();
    end
endmodule : digital_heterodyne_mixer_tb
